//--- hw/muxed_bus_pkg.sv
package muxed_bus_pkg;

  // ==========================================================
  // Register numbers and field positions
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_VECTOR = 4'h2;
  localparam logic [3:0] REG_WR3 = 4'h3;
  localparam logic [3:0] REG_WR4 = 4'h4;
  localparam logic [3:0] REG_WR5 = 4'h5;
  localparam logic [3:0] REG_EXT = 4'h7;
  localparam logic [3:0] REG_MASTER = 4'h9;
  localparam logic [3:0] REG_WR10 = 4'ha;
  localparam logic [3:0] REG_EXT_IRQ = 4'hf;
  localparam int MIC_NO_VECTOR_BIT = 1;
  localparam int MIC_IRQ_ENABLE_BIT = 3;
  localparam int EXT_READ_BIT = 6;
  localparam int FIFO_EN_BIT = 2;
  localparam int EXT_SELECT_BIT = 0;
  localparam logic [1:0] CMD_SHIFT_LEFT = 2'h2;
  localparam logic [1:0] CMD_SHIFT_RIGHT = 2'h3;
  localparam logic [2:0] CMD_RESET_IUS = 3'h7;
  localparam logic CHAN_A = 1'b1;
  localparam logic CHAN_B = 1'b0;
  localparam int NUM_SOURCES = 6;
  localparam int RECOVERY_CYCLES = 4;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic as_n;
    logic ds_n;
    logic cs0_n;
    logic cs1;
    logic ack_n;
    logic rw;
    logic cei;
    logic [7:0] bus;
  } pins_t;

  localparam pins_t PINS_IDLE = '{as_n: 1'b1, ds_n: 1'b1, cs0_n: 1'b1, cs1: 1'b0,
                                  ack_n: 1'b1, rw: 1'b1, cei: 1'b0, bus: 8'h00};

  typedef struct packed {
    logic chan;
    logic [3:0] num;
  } reg_sel_t;

  typedef struct packed {
    logic valid;
    logic chan;
    logic [3:0] num;
    logic [7:0] data;
  } wr_req_t;

  typedef enum logic [2:0] {WSEL_NONE, WSEL_WR3, WSEL_WR4, WSEL_WR5, WSEL_WR10, WSEL_EXT} wsel_t;

  typedef struct packed {
    logic as_prev;
    logic ds_prev;
    logic [7:0] addr;
    logic cs0_n;
    logic ack_n;
    logic shift_right;
    logic active;
    logic rw;
    logic ack_done;
    logic vec_on;
    logic irq_release;
    logic [7:0] dout;
    logic [NUM_SOURCES-1:0] pending;
    logic [NUM_SOURCES-1:0] irq_in_service;
    logic [1:0][15:0][7:0] wreg;
    logic [1:0][7:0] ext;
    wr_req_t wr;
    logic chip_reset;
  } hif_state_t;

endpackage : muxed_bus_pkg

//--- hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
  import muxed_bus_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire pins_t pins_i,
  output pins_t pins_o
);

  // ==========================================================
  // Two flops per pin; the first stage feeds only the second.
  logic [$bits(pins_t)-1:0] meta_q;
  logic [$bits(pins_t)-1:0] sync_q;
  logic [$bits(pins_t)-1:0] idle;

  assign idle = PINS_IDLE;

  genvar i;
  generate
    for (i = 0; i < $bits(pins_t); i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!resetn) begin
          meta_q[i] <= idle[i];
          sync_q[i] <= idle[i];
        end else begin
          meta_q[i] <= pins_i[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign pins_o = sync_q;

endmodule : pin_sync

//--- hw/read_alias.sv
`timescale 1ns/1ps
module read_alias
  import muxed_bus_pkg::*;
(
  input wire logic [3:0] num,
  input wire logic ext_read,
  input wire logic fifo_en,
  output logic [3:0] rd_num,
  output wsel_t wsel
);

  // ==========================================================
  // Incomplete decode keeps the read mux small.
  always_comb begin
    rd_num = num;
    wsel = WSEL_NONE;
    unique case (num)
      4'h4: if (ext_read) wsel = WSEL_WR4; else rd_num = 4'h0;
      4'h5: if (ext_read) wsel = WSEL_WR5; else rd_num = 4'h1;
      4'h6: if (!fifo_en) rd_num = 4'h2;
      4'h7: if (!fifo_en) rd_num = 4'h3;
      4'h9: if (ext_read) wsel = WSEL_WR3; else rd_num = 4'hd;
      4'hb: if (ext_read) wsel = WSEL_WR10; else rd_num = 4'hf;
      4'he: if (ext_read) wsel = WSEL_EXT;
      default: rd_num = num;
    endcase
  end

endmodule : read_alias

//--- hw/muxed_bus_host_interface.sv
`timescale 1ns/1ps
// Summary of operation
// - Address strobe rise latches address, select, acknowledge.
// - High select needed throughout any transfer.
// - Both strobes low means hardware reset.
// - Pending bits update only on address strobes.
// - Reads drive bus while selected, strobe low.
// - Writes capture data at select/strobe coincidence.
// - Acknowledge cycle ignores address, selects, direction.
// - Late acknowledge recognised on following strobe.
// - Acknowledge sets in-service, drives vector.
// - Master control bit 1 suppresses vector.
// - Acknowledge strobe fall releases interrupt request.
// - Command selects shift mode; reset selects left.
// - Left mode: number bits 4-1, channel bit 5.
// - Right mode: number bits 4-1, channel bit 0.
// - Vector and master registers shared, both channels.
// - Missing read registers alias existing ones.
// - Selected write registers can be read back.
// - Extended read maps aliases to write registers.
// - Status FIFO enable exposes read registers 6, 7.
// - Chain output high only when chain input high, none in service.
module muxed_bus_host_interface
  import muxed_bus_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic addr_latch_strobe_n,
  input wire logic transfer_strobe_n,
  input wire logic latched_select_n,
  input wire logic held_select,
  input wire logic read_write,
  input wire logic irq_ack_n,
  input wire logic chain_enable_in,
  input wire logic [7:0] muxed_addr_data_i,
  output logic [7:0] muxed_addr_data_o,
  output logic muxed_addr_data_oe,
  output logic chain_enable_out,
  output logic irq_n_o,
  output logic irq_n_oe,
  input wire logic [NUM_SOURCES-1:0] irq_sources,
  output reg_sel_t read_sel,
  input wire logic [7:0] read_value,
  output wr_req_t write_req,
  output logic shift_right,
  output logic chip_reset
);

  // ==========================================================
  // Pin synchronisation
  pins_t pins_raw;
  pins_t s;

  assign pins_raw = '{as_n: addr_latch_strobe_n, ds_n: transfer_strobe_n,
                      cs0_n: latched_select_n, cs1: held_select, ack_n: irq_ack_n,
                      rw: read_write, cei: chain_enable_in, bus: muxed_addr_data_i};

  pin_sync u_sync (
    .clk(clk),
    .resetn(resetn),
    .pins_i(pins_raw),
    .pins_o(s)
  );

  // ==========================================================
  // State
  localparam hif_state_t STATE_RESET = '0;

  hif_state_t st_q;
  hif_state_t st_d;

  logic as_rise;
  logic ds_fall;
  logic hw_reset;
  logic xfer_go;
  logic sel_chan;
  logic [3:0] sel_num;
  logic ext_read;
  logic fifo_en;
  logic [3:0] rd_num;
  wsel_t wsel;
  logic [7:0] rd_data;
  logic [2:0] hi_src;
  logic hi_found;
  logic [2:0] ius_top;
  logic ius_any;
  logic request;
  logic [7:0] vector;

  assign as_rise = s.as_n && !st_q.as_prev;
  assign ds_fall = !s.ds_n && st_q.ds_prev;
  assign hw_reset = !s.as_n && !s.ds_n;

  // ==========================================================
  // Address decode
  assign sel_num = st_q.addr[4:1];
  // A one on the select bit picks channel A in either mode.
  assign sel_chan = st_q.shift_right ? st_q.addr[0] : st_q.addr[5];
  assign ext_read = st_q.ext[sel_chan][EXT_READ_BIT];
  assign fifo_en = st_q.wreg[sel_chan][REG_EXT_IRQ][FIFO_EN_BIT];

  read_alias u_alias (
    .num(sel_num),
    .ext_read(ext_read),
    .fifo_en(fifo_en),
    .rd_num(rd_num),
    .wsel(wsel)
  );

  assign read_sel = '{chan: sel_chan, num: rd_num};

  always_comb begin
    rd_data = read_value;
    unique case (wsel)
      WSEL_WR3: rd_data = st_q.wreg[sel_chan][REG_WR3];
      WSEL_WR4: rd_data = st_q.wreg[sel_chan][REG_WR4];
      WSEL_WR5: rd_data = st_q.wreg[sel_chan][REG_WR5];
      WSEL_WR10: rd_data = st_q.wreg[sel_chan][REG_WR10];
      WSEL_EXT: rd_data = st_q.ext[sel_chan];
      WSEL_NONE: rd_data = read_value;
    endcase
  end

  // ==========================================================
  // Interrupt priority; the highest source index wins.
  always_comb begin
    hi_src = 3'h0;
    hi_found = 1'b0;
    ius_top = 3'h0;
    ius_any = 1'b0;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (st_q.pending[i]) begin
        hi_src = 3'(i);
        hi_found = 1'b1;
      end
      if (st_q.irq_in_service[i]) begin
        ius_top = 3'(i);
        ius_any = 1'b1;
      end
    end
  end

  assign request = st_q.wreg[0][REG_MASTER][MIC_IRQ_ENABLE_BIT] && hi_found &&
                   (!ius_any || hi_src > ius_top);
  assign vector = {st_q.wreg[0][REG_VECTOR][7:4], hi_src, st_q.wreg[0][REG_VECTOR][0]};

  // ==========================================================
  // Next state
  assign xfer_go = st_q.ack_n && !st_q.cs0_n && s.cs1 && !s.ds_n && !st_q.active;

  always_comb begin
    st_d = st_q;
    st_d.as_prev = s.as_n;
    st_d.ds_prev = s.ds_n;
    st_d.wr.valid = 1'b0;
    st_d.chip_reset = 1'b0;
    if (as_rise) begin
      st_d.addr = s.bus;
      st_d.cs0_n = s.cs0_n;
      // A late acknowledge simply shows up at the next latch edge.
      st_d.ack_n = s.ack_n;
      st_d.pending = irq_sources;
      st_d.ack_done = 1'b0;
      st_d.irq_release = 1'b0;
    end
    if (s.ds_n || !s.cs1) begin
      st_d.active = 1'b0;
    end
    if (s.ds_n) begin
      st_d.vec_on = 1'b0;
    end
    if (xfer_go) begin
      st_d.active = 1'b1;
      st_d.rw = s.rw;
      st_d.dout = rd_data;
      if (!s.rw) begin
        st_d.wr = '{valid: 1'b1, chan: sel_chan, num: sel_num, data: s.bus};
        if (sel_num == REG_VECTOR || sel_num == REG_MASTER) begin
          st_d.wreg[0][sel_num] = s.bus;
        end else if (sel_num == REG_EXT && st_q.wreg[sel_chan][REG_EXT_IRQ][EXT_SELECT_BIT]) begin
          st_d.ext[sel_chan] = s.bus;
        end else begin
          st_d.wreg[sel_chan][sel_num] = s.bus;
        end
        if (sel_num == REG_CMD && sel_chan == CHAN_B) begin
          if (s.bus[1:0] == CMD_SHIFT_LEFT) begin
            st_d.shift_right = 1'b0;
          end else if (s.bus[1:0] == CMD_SHIFT_RIGHT) begin
            st_d.shift_right = 1'b1;
          end
        end
        if (sel_num == REG_CMD && s.bus[5:3] == CMD_RESET_IUS && ius_any) begin
          st_d.irq_in_service[ius_top] = 1'b0;
        end
      end
    end
    // Only the first data strobe of an acknowledge cycle is acted on.
    if (ds_fall && !st_q.ack_n && !st_q.ack_done) begin
      st_d.ack_done = 1'b1;
      if (request && s.cei) begin
        st_d.irq_in_service[hi_src] = 1'b1;
        st_d.dout = vector;
        st_d.vec_on = !st_q.wreg[0][REG_MASTER][MIC_NO_VECTOR_BIT];
        st_d.irq_release = 1'b1;
      end
    end
    if (hw_reset) begin
      st_d = STATE_RESET;
      st_d.as_prev = s.as_n;
      st_d.ds_prev = s.ds_n;
      st_d.ack_n = 1'b1;
      st_d.cs0_n = 1'b1;
      st_d.chip_reset = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= STATE_RESET;
      st_q.as_prev <= 1'b1;
      st_q.ds_prev <= 1'b1;
      st_q.ack_n <= 1'b1;
      st_q.cs0_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs
  // The enable is gated by the synchronised strobe, so the bus is
  // released two clocks after the strobe rises; hold time must allow it.
  assign muxed_addr_data_oe = (st_q.active && st_q.rw && s.cs1 && !s.ds_n) ||
                              (st_q.vec_on && !s.ds_n);
  assign muxed_addr_data_o = st_q.dout;
  assign irq_n_o = 1'b0;
  assign irq_n_oe = request && !st_q.irq_release;
  assign chain_enable_out = s.cei && !ius_any && !(!st_q.ack_n && request);
  assign write_req = st_q.wr;
  assign shift_right = st_q.shift_right;
  assign chip_reset = st_q.chip_reset;

  // ==========================================================
  // Checks
  strobe_reset_a: assert property (@(posedge clk) disable iff (!resetn)
    hw_reset |=> chip_reset && !shift_right && st_q.irq_in_service == '0)
    else $error("Coincident strobes did not reset the interface.");

  addr_latch_a: assert property (@(posedge clk) disable iff (!resetn)
    as_rise && !hw_reset |=> st_q.addr == $past(s.bus))
    else $error("Address not latched on strobe rise.");

  pending_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !as_rise && !hw_reset |=> $stable(st_q.pending))
    else $error("Pending bits changed without address strobe.");

  read_drive_a: assert property (@(posedge clk) disable iff (!resetn)
    muxed_addr_data_oe |-> !s.ds_n && (s.cs1 || st_q.vec_on))
    else $error("Bus driven outside data strobe.");

  write_select_a: assert property (@(posedge clk) disable iff (!resetn)
    write_req.valid |-> $past(!st_q.cs0_n && st_q.ack_n && s.cs1 && !s.rw))
    else $error("Write taken without valid select.");

  ack_service_a: assert property (@(posedge clk) disable iff (!resetn)
    ds_fall && !st_q.ack_n && !st_q.ack_done && request && s.cei && !hw_reset
    |=> st_q.irq_in_service != '0 && st_q.irq_release && !irq_n_oe)
    else $error("Acknowledge did not service the interrupt.");

  no_vector_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q.wreg[0][REG_MASTER][MIC_NO_VECTOR_BIT] && $stable(st_q.wreg[0][REG_MASTER])
    |=> !st_q.vec_on)
    else $error("Vector driven while suppressed.");

  chain_out_a: assert property (@(posedge clk) disable iff (!resetn)
    chain_enable_out |-> s.cei && st_q.irq_in_service == '0)
    else $error("Chain output high while servicing.");

  shift_cmd_a: assert property (@(posedge clk) disable iff (!resetn)
    xfer_go && !s.rw && sel_num == REG_CMD && sel_chan == CHAN_B &&
    s.bus[1:0] == CMD_SHIFT_RIGHT && !hw_reset |=> shift_right)
    else $error("Shift command not applied.");

  read_load_a: assert property (@(posedge clk) disable iff (!resetn)
    xfer_go && s.rw && !hw_reset |=> st_q.dout == $past(rd_data))
    else $error("Read data not loaded at the transfer edge.");

  write_pulse_a: assert property (@(posedge clk) disable iff (!resetn)
    write_req.valid |=> !write_req.valid)
    else $error("Write request held for more than one cycle.");

  write_take_a: assert property (@(posedge clk) disable iff (!resetn)
    xfer_go && !s.rw && !hw_reset |=> write_req.valid && write_req.data == $past(s.bus))
    else $error("Write data not captured at the transfer edge.");

  ack_ignore_a: assert property (@(posedge clk) disable iff (!resetn)
    !st_q.ack_n |=> !write_req.valid)
    else $error("Write taken during an acknowledge cycle.");

  late_ack_a: assert property (@(posedge clk) disable iff (!resetn)
    as_rise && !s.ack_n && !ds_fall && !hw_reset |=> !st_q.ack_n && !st_q.ack_done)
    else $error("Acknowledge not taken at the address strobe.");

  single_service_a: assert property (@(posedge clk) disable iff (!resetn)
    st_q.ack_done && !hw_reset |=> $stable(st_q.irq_in_service))
    else $error("Second data strobe serviced again.");

  vector_value_a: assert property (@(posedge clk) disable iff (!resetn)
    ds_fall && !st_q.ack_n && !st_q.ack_done && request && s.cei && !hw_reset
    |=> st_q.dout == $past(vector))
    else $error("Wrong vector loaded at acknowledge.");

  vector_enable_a: assert property (@(posedge clk) disable iff (!resetn)
    ds_fall && !st_q.ack_n && !st_q.ack_done && request && s.cei && !hw_reset &&
    !st_q.wreg[0][REG_MASTER][MIC_NO_VECTOR_BIT] |=> st_q.vec_on)
    else $error("Vector not enabled at acknowledge.");

  no_service_a: assert property (@(posedge clk) disable iff (!resetn)
    ds_fall && !st_q.ack_n && !s.cei && !hw_reset |=> $stable(st_q.irq_in_service) && !st_q.vec_on)
    else $error("Acknowledge serviced with the chain input low.");

  shift_left_a: assert property (@(posedge clk) disable iff (!resetn)
    xfer_go && !s.rw && sel_num == REG_CMD && sel_chan == CHAN_B &&
    s.bus[1:0] == CMD_SHIFT_LEFT && !hw_reset |=> !shift_right)
    else $error("Shift left command not applied.");

  shared_vector_a: assert property (@(posedge clk) disable iff (!resetn)
    xfer_go && !s.rw && sel_num == REG_VECTOR && !hw_reset
    |=> st_q.wreg[0][REG_VECTOR] == $past(s.bus))
    else $error("Shared vector register not written.");

  ext_readback_a: assert property (@(posedge clk) disable iff (!resetn)
    xfer_go && s.rw && ext_read && sel_num == 4'h9 && !hw_reset
    |=> st_q.dout == $past(st_q.wreg[sel_chan][REG_WR3]))
    else $error("Write register not read back.");

  alias_four_a: assert property (@(posedge clk) disable iff (!resetn)
    sel_num == 4'h4 |-> read_sel.num == (ext_read ? 4'h4 : 4'h0))
    else $error("Read alias for register four wrong.");

  alias_nine_a: assert property (@(posedge clk) disable iff (!resetn)
    !ext_read && sel_num == 4'h9 |-> read_sel.num == 4'hd)
    else $error("Read alias for register nine wrong.");

  fifo_alias_a: assert property (@(posedge clk) disable iff (!resetn)
    sel_num == 4'h6 |-> read_sel.num == (fifo_en ? 4'h6 : 4'h2))
    else $error("Status read alias wrong.");

  chain_ack_a: assert property (@(posedge clk) disable iff (!resetn)
    !st_q.ack_n && request |-> !chain_enable_out)
    else $error("Chain output high while requesting in acknowledge.");

  bus_release_a: assert property (@(posedge clk) disable iff (!resetn)
    s.ds_n |-> !muxed_addr_data_oe)
    else $error("Bus driven with the data strobe high.");

endmodule : muxed_bus_host_interface

//--- test/host_cpu_model.sv
`timescale 1ns/1ps
module host_cpu_model
  import muxed_bus_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] bus_wire,
  input wire logic dev_oe,
  output pins_t pins,
  output logic drive
);
  // ====
  // Bus cycles, every pin moves on the falling clock edge.
  initial begin
    pins = PINS_IDLE;
    drive = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_clk

  task automatic set_chain(input logic v);
    pins.cei = v;
  endtask : set_chain

  // The strobe also refreshes pending bits, so even ignored cycles pulse it.
  task automatic addr_phase(input logic [7:0] a, input logic sel_n, input logic ack_n);
    pins.bus = a;
    drive = 1'b1;
    pins.cs0_n = sel_n;
    pins.ack_n = ack_n;
    pins.as_n = 1'b0;
    wait_clk(4);
    pins.as_n = 1'b1;
    wait_clk(4);
  endtask : addr_phase

  task automatic data_phase(input logic rd, input logic [7:0] d, input logic sel,
                            output logic [7:0] q, output logic oe);
    pins.rw = rd;
    pins.bus = d;
    drive = !rd;
    pins.cs1 = sel;
    wait_clk(1);
    pins.ds_n = 1'b0;
    wait_clk(6);
    q = bus_wire;
    oe = dev_oe;
    pins.ds_n = 1'b1;
    wait_clk(1);
    pins.cs1 = 1'b0;
    pins.ack_n = 1'b1;
    pins.cs0_n = 1'b1;
    wait_clk(3);
  endtask : data_phase

  task automatic hw_reset();
    pins.as_n = 1'b0;
    pins.ds_n = 1'b0;
    wait_clk(4);
    pins.as_n = 1'b1;
    pins.ds_n = 1'b1;
    wait_clk(4);
  endtask : hw_reset
endmodule : host_cpu_model

//--- test/muxed_bus_host_interface_tb.sv
`timescale 1ns/1ps
module muxed_bus_host_interface_tb
  import muxed_bus_pkg::*;
();
  // ====
  // Harness
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [NUM_SOURCES-1:0] irq_sources = '0;
  pins_t pins;
  logic drive;
  logic [7:0] bus_wire;
  logic [7:0] dout;
  logic [7:0] read_value;
  logic oe, ceo, irq_n, irq_oe, sr_out, rst_pulse;
  reg_sel_t read_sel;
  wr_req_t write_req;
  wr_req_t last_wr;
  int n_errors = 0;
  int comparisons = 0;
  int n_wr = 0;
  int n_rst = 0;
  int cycles = 0;
  logic shift_mode = 1'b0;
  logic [31:0] seed = 32'he59cf032;
  logic [7:0] shadow [2][16];
  logic [7:0] ext_shadow [2];

  always #12.5 clk = ~clk;
  // An undriven bus shows the inverse of its last value, never a stale copy.
  assign bus_wire = oe ? dout : (drive ? pins.bus : ~pins.bus);
  assign read_value = {3'h5, read_sel};

  host_cpu_model i_host_cpu_model (.clk(clk), .bus_wire(bus_wire), .dev_oe(oe),
    .pins(pins), .drive(drive));

  muxed_bus_host_interface i_muxed_bus_host_interface (
    .clk(clk), .resetn(resetn), .addr_latch_strobe_n(pins.as_n),
    .transfer_strobe_n(pins.ds_n), .latched_select_n(pins.cs0_n), .held_select(pins.cs1),
    .read_write(pins.rw), .irq_ack_n(pins.ack_n), .chain_enable_in(pins.cei),
    .muxed_addr_data_i(bus_wire), .muxed_addr_data_o(dout), .muxed_addr_data_oe(oe),
    .chain_enable_out(ceo), .irq_n_o(irq_n), .irq_n_oe(irq_oe), .irq_sources(irq_sources),
    .read_sel(read_sel), .read_value(read_value), .write_req(write_req),
    .shift_right(sr_out), .chip_reset(rst_pulse));

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (write_req.valid === 1'b1) begin
      n_wr <= n_wr + 1;
      last_wr <= write_req;
    end
    if (rst_pulse === 1'b1) n_rst <= n_rst + 1;
  end

  always @(negedge clk) begin
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      finish_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [7:0] addr_of(input logic c, input logic [3:0] n);
    return shift_mode ? {3'h0, n, c} : {2'h0, c, n, 1'b0};
  endfunction : addr_of

  function automatic logic [7:0] exp_rd(input logic c, input logic [3:0] n);
    logic [3:0] r;
    if (ext_shadow[c][EXT_READ_BIT]) begin
      case (n)
        4'h4, 4'h5: return shadow[c][n];
        4'h9: return shadow[c][3];
        4'hb: return shadow[c][10];
        4'he: return ext_shadow[c];
        default: ;
      endcase
    end
    case (n)
      4'h4, 4'h5: r = n - 4'h4;
      4'h6, 4'h7: r = shadow[c][REG_EXT_IRQ][FIFO_EN_BIT] ? n : n - 4'h4;
      4'h9: r = 4'hd;
      4'hb: r = 4'hf;
      default: r = n;
    endcase
    return {3'h5, c, r};
  endfunction : exp_rd

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic c, input logic [3:0] n, input logic [7:0] d);
    int n0;
    logic [7:0] q;
    logic o;
    n0 = n_wr;
    i_host_cpu_model.addr_phase(addr_of(c, n), 1'b0, 1'b1);
    i_host_cpu_model.data_phase(1'b0, d, 1'b1, q, o);
    check(16'(n_wr - n0), 16'h1);
    check({2'h0, last_wr}, {3'h1, c, n, d});
    if (n == REG_VECTOR || n == REG_MASTER) begin
      shadow[0][n] = d;
      shadow[1][n] = d;
    end else if (n == REG_EXT && shadow[c][REG_EXT_IRQ][EXT_SELECT_BIT]) begin
      ext_shadow[c] = d;
    end else begin
      shadow[c][n] = d;
    end
    if (n == REG_CMD && c == CHAN_B && d[1]) shift_mode = d[0];
  endtask : wr

  task automatic rd(input logic c, input logic [3:0] n);
    logic [7:0] q;
    logic o;
    i_host_cpu_model.addr_phase(addr_of(c, n), 1'b0, 1'b1);
    i_host_cpu_model.data_phase(1'b1, 8'h00, 1'b1, q, o);
    check({15'h0, o}, 16'h1);
    check({8'h0, q}, {8'h0, exp_rd(c, n)});
    check({15'h0, oe}, 16'h0);
  endtask : rd

  task automatic refused(input logic sel_n, input logic sel, input logic rdn);
    int n0;
    logic [7:0] q;
    logic o;
    n0 = n_wr;
    i_host_cpu_model.addr_phase(addr_of(CHAN_A, 4'h1), sel_n, 1'b1);
    i_host_cpu_model.data_phase(rdn, 8'h5a, sel, q, o);
    check(16'(n_wr - n0) + {15'h0, o}, 16'h0);
  endtask : refused

  task automatic ack(input logic cei, input logic exp_oe, input logic [7:0] exp_q);
    int n0;
    logic [7:0] q;
    logic o;
    n0 = n_wr;
    i_host_cpu_model.set_chain(cei);
    i_host_cpu_model.addr_phase(8'h00, 1'b1, 1'b1);
    i_host_cpu_model.addr_phase(8'hff, 1'b1, 1'b0);
    i_host_cpu_model.data_phase(1'b1, 8'h00, 1'b0, q, o);
    check({7'h0, o, exp_oe ? q : 8'h0}, {7'h0, exp_oe, exp_q});
    check(16'(n_wr - n0), 16'h0);
    if (cei) check({14'h0, irq_oe, ceo}, 16'h0);
    else check({14'h0, irq_oe, ceo}, 16'h2);
    i_host_cpu_model.set_chain(1'b1);
  endtask : ack

  task automatic finish_test();
    $display("Comparisons %0d, errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  initial begin
    int n0;
    logic [3:0] num;
    foreach (shadow[c, n]) shadow[c][n] = 8'h00;
    ext_shadow = '{8'h00, 8'h00};
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    i_host_cpu_model.set_chain(1'b1);
    i_host_cpu_model.wait_clk(3);
    check({15'h0, sr_out}, 16'h0);
    refused(1'b1, 1'b1, 1'b0);
    refused(1'b0, 1'b0, 1'b0);
    refused(1'b1, 1'b1, 1'b1);
    refused(1'b0, 1'b0, 1'b1);
    for (int md = 0; md < 2; md++) begin
      if (md == 1) begin
        wr(CHAN_B, REG_CMD, 8'h03);
        check({15'h0, sr_out}, 16'h1);
      end
      for (int n = 0; n < 16; n++) rd(CHAN_B, 4'(n));
      wr(CHAN_A, REG_EXT_IRQ, 8'h05);
      wr(CHAN_A, REG_EXT, 8'h40);
      for (int n = 0; n < 16; n++) rd(CHAN_A, 4'(n));
      for (int k = 0; k < 12; k++) begin
        seed = lfsr(seed);
        num = seed[3:0];
        if (num inside {REG_CMD, REG_EXT, REG_MASTER, REG_EXT_IRQ}) num = REG_WR10;
        wr(seed[4], num, seed[15:8]);
        rd(seed[4], num);
      end
    end
    wr(CHAN_B, REG_CMD, 8'h02);
    check({15'h0, sr_out}, 16'h0);
    rd(CHAN_A, 4'h9);
    wr(CHAN_B, REG_CMD, 8'h03);
    wr(CHAN_B, REG_VECTOR, 8'h5a);
    wr(CHAN_A, REG_MASTER, 8'h08);
    irq_sources = 6'h0a;
    i_host_cpu_model.wait_clk(8);
    check({15'h0, irq_oe}, 16'h0);
    i_host_cpu_model.addr_phase(8'h00, 1'b1, 1'b1);
    check({13'h0, irq_n, irq_oe, ceo}, 16'h3);
    ack(1'b1, 1'b1, 8'h56);
    wr(CHAN_B, REG_CMD, 8'h38);
    check({15'h0, ceo}, 16'h1);
    irq_sources = 6'h21;
    wr(CHAN_A, REG_VECTOR, 8'hc3);
    ack(1'b1, 1'b1, 8'hcb);
    wr(CHAN_B, REG_CMD, 8'h38);
    wr(CHAN_B, REG_MASTER, 8'h0a);
    ack(1'b1, 1'b0, 8'h00);
    wr(CHAN_B, REG_CMD, 8'h38);
    wr(CHAN_B, REG_MASTER, 8'h08);
    ack(1'b0, 1'b0, 8'h00);
    irq_sources = '0;
    n0 = n_rst;
    i_host_cpu_model.hw_reset();
    // The reset pulse lasts while both strobes stay low, four clocks here.
    check(16'(n_rst - n0), 16'h4);
    check({15'h0, sr_out}, 16'h0);
    shift_mode = 1'b0;
    foreach (shadow[c, n]) shadow[c][n] = 8'h00;
    ext_shadow = '{8'h00, 8'h00};
    rd(CHAN_A, 4'h4);
    finish_test();
  end
endmodule : muxed_bus_host_interface_tb
